// file: design/tss_pkg.sv
// Shared constants and carrier types for the tamper self-test supervisor
package tss_pkg;
	localparam int TSS_CHANNELS = 4;
	localparam int TSS_LEDS = 4;
	localparam int TSS_LOG_DEPTH = 100;
	localparam int TSS_LOG_PTR_W = 7;
	localparam int TSS_STAMP_W = 32;
	localparam int TSS_TEST_ITEMS = 4;
	localparam int TSS_CLK_HZ = 20_000_000;
	localparam int TSS_BEEP_MS = 100;
	localparam int TSS_BEEP_CYC = TSS_CLK_HZ / 1000 * TSS_BEEP_MS;
	localparam int TSS_TEST_TIMEOUT_MS = 500;
	localparam int TSS_TEST_TIMEOUT_CYC = TSS_CLK_HZ / 1000 * TSS_TEST_TIMEOUT_MS;
	localparam logic [1:0] TSS_MODE_FULL = 2'h1;
	localparam logic [1:0] TSS_MODE_KM = 2'h2;
	localparam logic [1:0] TSS_MODE_CUSTOM = 2'h3;
	localparam logic [TSS_LOG_PTR_W-1:0] TSS_PTR_RST = 7'h00;
	localparam logic [TSS_CHANNELS-1:0] TSS_CH_ISOLATE = 4'h0;

	typedef enum logic [3:0] {
		TSS_EV_NONE = 4'h0,
		ev_admin_logon = 4'h1,
		ev_admin_logoff = 4'h2,
		ev_arming = 4'h3,
		ev_auth_port_config = 4'h4,
		ev_display_id_learn = 4'h5,
		ev_log_dump = 4'h6,
		ev_power_up = 4'h7,
		ev_mode_upload = 4'h8,
		ev_rejected_auth_device = 4'h9,
		ev_factory_restore = 4'ha,
		ev_rejected_input_device = 4'hb,
		ev_self_test = 4'hc,
		ev_tampered = 4'hd,
		ev_user_logon = 4'he,
		ev_user_logoff = 4'hf
	} tss_event_t;

	typedef struct packed {
		tss_event_t kind;
		logic [1:0] arg;
		logic pass;
		logic [TSS_STAMP_W-1:0] stamp;
	} tss_log_entry_t;

	typedef struct packed {
		logic valid;
		tss_log_entry_t entry;
	} tss_log_req_t;

	typedef struct packed {
		logic [TSS_TEST_ITEMS-1:0] done;
		logic [TSS_TEST_ITEMS-1:0] fail;
	} tss_test_res_t;
endpackage : tss_pkg

// file: design/tss_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module tss_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [WIDTH-1:0] async_in,
	input wire logic [WIDTH-1:0] rst_val,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} tss_sync_st_t;
	tss_sync_st_t st_reg;
	tss_sync_st_t st_next;

	always_comb begin
		st_next = st_reg;
		if (clk_en) begin
			st_next.s1 = async_in;
			st_next.s2 = st_reg.s1;
		end
	end

	// Reset value is a constant from the instantiating module
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_reg <= {rst_val, rst_val};
		end else begin
			st_reg <= st_next;
		end
	end

	assign sync_out = st_reg.s2;
endmodule : tss_sync

// file: design/tss_log.sv
// Wrap-around security event log with oldest-first readout
`timescale 1ns/1ps
module tss_log
	import tss_pkg::*;
#(
	parameter int DEPTH = TSS_LOG_DEPTH
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire tss_log_req_t wr_req,
	input wire logic rd_start,
	input wire logic rd_next,
	input wire logic wipe,
	output tss_log_entry_t rd_entry,
	output logic rd_valid,
	output logic [TSS_LOG_PTR_W-1:0] count
);
	typedef struct packed {
		logic [TSS_LOG_PTR_W-1:0] wr_ptr;
		logic [TSS_LOG_PTR_W-1:0] rd_ptr;
		logic [TSS_LOG_PTR_W-1:0] cnt;
		logic [TSS_LOG_PTR_W-1:0] rd_left;
		logic rd_valid;
		tss_log_entry_t rd_entry;
	} tss_log_st_t;
	tss_log_st_t st_reg;
	tss_log_st_t st_next;
	tss_log_entry_t mem [DEPTH];
	localparam logic [TSS_LOG_PTR_W-1:0] LAST = TSS_LOG_PTR_W'(DEPTH - 1);
	localparam logic [TSS_LOG_PTR_W-1:0] FULL = TSS_LOG_PTR_W'(DEPTH);

	function automatic logic [TSS_LOG_PTR_W-1:0] wrap_inc(input logic [TSS_LOG_PTR_W-1:0] p);
		wrap_inc = (p == LAST) ? TSS_PTR_RST : p + 7'h01;
	endfunction : wrap_inc

	always_comb begin
		logic [TSS_LOG_PTR_W-1:0] oldest;
		oldest = (st_reg.cnt == FULL) ? st_reg.wr_ptr : TSS_PTR_RST;
		st_next = st_reg;
		st_next.rd_valid = 1'b0;
		if (clk_en) begin
			if (wipe) begin
				st_next = '0;
			end else begin
				if (wr_req.valid) begin
					st_next.wr_ptr = wrap_inc(st_reg.wr_ptr);
					if (st_reg.cnt != FULL) begin
						st_next.cnt = st_reg.cnt + 7'h01;
					end
				end
				if (rd_start) begin
					st_next.rd_ptr = oldest;
					st_next.rd_left = st_reg.cnt;
				end else if (rd_next && st_reg.rd_left != TSS_PTR_RST) begin
					st_next.rd_entry = mem[st_reg.rd_ptr];
					st_next.rd_valid = 1'b1;
					st_next.rd_ptr = wrap_inc(st_reg.rd_ptr);
					st_next.rd_left = st_reg.rd_left - 7'h01;
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (clk_en && wipe) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= '0;
			end
		end else if (clk_en && wr_req.valid) begin
			mem[st_reg.wr_ptr] <= wr_req.entry;
		end
	end

	assign rd_entry = st_reg.rd_entry;
	assign rd_valid = st_reg.rd_valid;
	assign count = st_reg.cnt;

	log_bound_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		st_reg.cnt <= FULL) else $error("log count above depth");
endmodule : tss_log

// file: design/tss_supervisor.sv
// Tamper and power-up self-test supervisor with event log
// Overview of operation
// - Tamper only from detection or test failure
// - Tamper state never cleared except at power-on
// - Tamper isolates channels and opens relays
// - Tamper erases all stored information
// - Tamper repeats LED flash, beep, relay pulse
// - Enclosure-open switch enters tamper
// - Low backup battery enters tamper
// - Self-test after power, restore, reset
// - Test buttons, firmware, tamper, isolation
// - Test failure disables until reset; flagged failure until power cycle
// - Test failure lights all LEDs
// - Pass gives one beep, one relay pulse
// - Log events in order, stamped, pass/fail
// - Fifteen distinct event types
// - Mode codes 01, 02, 03
// - Hundred entries, oldest overwritten
// - Log dump only to authenticated admin
// - Programming ports always disabled
// - Channels deselected until test ends
`timescale 1ns/1ps
module tss_supervisor
	import tss_pkg::*;
#(
	parameter int CHANNELS = TSS_CHANNELS,
	parameter int LEDS = TSS_LEDS,
	parameter int BEEP_CYC = TSS_BEEP_CYC,
	parameter int TEST_TIMEOUT_CYC = TSS_TEST_TIMEOUT_CYC
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic enclosure_open,
	input wire logic battery_low,
	input wire logic factory_restore,
	input wire tss_test_res_t test_res,
	input wire logic [CHANNELS-1:0] chan_sel_req,
	input wire tss_log_req_t log_req,
	input wire logic admin_auth,
	input wire logic dump_start,
	input wire logic dump_next,
	input wire logic prog_req,
	output logic test_run,
	output logic [CHANNELS-1:0] chan_sel,
	output logic relays_closed,
	output logic [LEDS-1:0] led_on,
	output logic speaker_on,
	output logic relay_pulse,
	output logic erase_all,
	output logic tamper_flag,
	output logic prog_enable,
	output tss_log_entry_t dump_entry,
	output logic dump_valid
);
	typedef enum logic [4:0] {
		TSS_ST_TEST = 5'h01,
		TSS_ST_PASS_BEEP = 5'h02,
		TSS_ST_PASS_RELAY = 5'h04,
		TSS_ST_RUN = 5'h08,
		TSS_ST_FAIL = 5'h10
	} tss_state_t;

	typedef struct packed {
		tss_state_t state;
		logic [31:0] timer;
		logic [TSS_STAMP_W-1:0] stamp;
		logic [CHANNELS-1:0] chan_sel;
		logic relays_closed;
		logic [LEDS-1:0] led_on;
		logic speaker_on;
		logic relay_pulse;
		logic blink;
		logic restore_d;
		logic logged_test;
	} tss_st_t;
	tss_st_t st_reg;
	tss_st_t st_next;

	// Tamper latch lives outside the reset domain
	logic tamper_reg;
	logic tamper_next;
	// Power-on marker, set once at the first clock edge
	logic tamper_init_reg = 1'b0;
	logic encl_s;
	logic batt_s;
	logic tamper_trig;
	tss_log_req_t log_wr;
	logic [TSS_LOG_PTR_W-1:0] log_count;

	tss_sync #(
		.WIDTH(2)
	) u_pin_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.async_in({enclosure_open, battery_low}),
		.rst_val(2'h0),
		.sync_out({encl_s, batt_s})
	);

	assign tamper_trig = encl_s || batt_s || st_reg.state == TSS_ST_FAIL &&
		test_res.fail != '0;

	always_comb begin
		tamper_next = tamper_reg;
		if (clk_en && tamper_trig) begin
			tamper_next = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!tamper_init_reg) begin
			tamper_reg <= 1'b0;
			tamper_init_reg <= 1'b1;
		end else begin
			tamper_reg <= tamper_next;
		end
	end

	always_comb begin
		st_next = st_reg;
		log_wr = '0;
		if (clk_en) begin
			st_next.stamp = st_reg.stamp + 32'h0000_0001;
			st_next.restore_d = factory_restore;
			st_next.relay_pulse = 1'b0;
			st_next.speaker_on = 1'b0;
			if (tamper_reg) begin
				st_next.chan_sel = TSS_CH_ISOLATE;
				st_next.relays_closed = 1'b0;
				if (st_reg.timer >= 32'(BEEP_CYC - 1)) begin
					st_next.timer = '0;
					st_next.blink = ~st_reg.blink;
				end else begin
					st_next.timer = st_reg.timer + 32'h0000_0001;
				end
				st_next.led_on = {LEDS{st_next.blink}};
				st_next.speaker_on = st_next.blink;
				st_next.relay_pulse = st_next.blink;
			end else begin
				case (st_reg.state)
					TSS_ST_TEST: begin
						st_next.chan_sel = TSS_CH_ISOLATE;
						st_next.relays_closed = 1'b0;
						st_next.timer = st_reg.timer + 32'h0000_0001;
						if (test_res.fail != '0 || st_reg.timer >= 32'(TEST_TIMEOUT_CYC - 1)) begin
							st_next.state = TSS_ST_FAIL;
							st_next.timer = '0;
							log_wr.valid = 1'b1;
							log_wr.entry = '{ev_self_test, 2'h0, 1'b0, st_reg.stamp};
						end else if (&test_res.done) begin
							st_next.state = TSS_ST_PASS_BEEP;
							st_next.timer = '0;
							log_wr.valid = 1'b1;
							log_wr.entry = '{ev_self_test, 2'h0, 1'b1, st_reg.stamp};
						end
					end
					TSS_ST_PASS_BEEP: begin
						st_next.speaker_on = 1'b1;
						st_next.timer = st_reg.timer + 32'h0000_0001;
						if (st_reg.timer >= 32'(BEEP_CYC - 1)) begin
							st_next.speaker_on = 1'b0;
							st_next.state = TSS_ST_PASS_RELAY;
							st_next.timer = '0;
						end
					end
					TSS_ST_PASS_RELAY: begin
						st_next.relay_pulse = 1'b1;
						st_next.timer = st_reg.timer + 32'h0000_0001;
						if (st_reg.timer >= 32'(BEEP_CYC - 1)) begin
							st_next.relay_pulse = 1'b0;
							st_next.state = TSS_ST_RUN;
							st_next.relays_closed = 1'b1;
						end
					end
					TSS_ST_RUN: begin
						st_next.chan_sel = chan_sel_req;
						if (factory_restore && !st_reg.restore_d) begin
							st_next.state = TSS_ST_TEST;
							st_next.timer = '0;
							st_next.chan_sel = TSS_CH_ISOLATE;
							st_next.relays_closed = 1'b0;
							log_wr.valid = 1'b1;
							log_wr.entry = '{ev_factory_restore, 2'h0, 1'b1, st_reg.stamp};
						end else begin
							log_wr = log_req;
						end
					end
					TSS_ST_FAIL: begin
						st_next.chan_sel = TSS_CH_ISOLATE;
						st_next.relays_closed = 1'b0;
						st_next.led_on = '1;
					end
					default: begin
						st_next.state = TSS_ST_FAIL;
					end
				endcase
			end
			if (tamper_trig && !tamper_reg) begin
				log_wr.valid = 1'b1;
				log_wr.entry = '{ev_tampered, 2'h0, 1'b0, st_reg.stamp};
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_reg <= '{TSS_ST_TEST, '0, '0, TSS_CH_ISOLATE, 1'b0, '0, 1'b0, 1'b0, 1'b0,
				1'b0, 1'b0};
		end else begin
			st_reg <= st_next;
		end
	end

	tss_log u_log (
		.clk_sys(clk_sys),
		// Log survives resets; cleared at power-on and wiped by tamper
		.sys_rst(!tamper_init_reg),
		.clk_en(clk_en),
		.wr_req(log_wr),
		// Dump only for admin, never after tamper
		.rd_start(dump_start && admin_auth && !tamper_reg),
		.rd_next(dump_next && admin_auth && !tamper_reg),
		.wipe(tamper_reg),
		.rd_entry(dump_entry),
		.rd_valid(dump_valid),
		.count(log_count)
	);

	assign test_run = st_reg.state == TSS_ST_TEST;
	assign chan_sel = st_reg.chan_sel;
	assign relays_closed = st_reg.relays_closed;
	assign led_on = st_reg.led_on;
	assign speaker_on = st_reg.speaker_on;
	assign relay_pulse = st_reg.relay_pulse;
	assign erase_all = tamper_reg;
	assign tamper_flag = tamper_reg;
	assign prog_enable = 1'b0;

	tamper_sticky_a: assert property (@(posedge clk_sys)
		tamper_reg |=> tamper_reg) else $error("tamper flag cleared");

	tamper_isolate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		tamper_reg && clk_en |=> chan_sel == '0 && !relays_closed)
		else $error("channels not isolated in tamper");

	test_desel_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		st_reg.state == TSS_ST_TEST |-> chan_sel == '0) else $error("channel selected in test");

	fail_leds_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		st_reg.state == TSS_ST_FAIL && !tamper_reg && clk_en |=> led_on == '1)
		else $error("fail LEDs not lit");

	fail_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		st_reg.state == TSS_ST_FAIL |=> st_reg.state == TSS_ST_FAIL)
		else $error("left fail state");

	sequence beep_done_seq;
		st_reg.state == TSS_ST_PASS_BEEP && st_reg.timer >= 32'(BEEP_CYC - 1) && clk_en;
	endsequence
	beep_relay_a: assert property (@(posedge clk_sys) disable iff (sys_rst || tamper_reg)
		beep_done_seq |=> st_reg.state == TSS_ST_PASS_RELAY && !speaker_on)
		else $error("beep not followed by relay pulse");
	pass_order_a: assert property (@(posedge clk_sys) disable iff (sys_rst || tamper_reg)
		$rose(st_reg.state == TSS_ST_PASS_RELAY) |-> $past(st_reg.state) == TSS_ST_PASS_BEEP)
		else $error("relay pulse without beep");

	encl_trig_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		encl_s && clk_en |=> tamper_reg) else $error("enclosure open missed");

	prog_off_a: assert property (@(posedge clk_sys)
		!prog_enable) else $error("programming enabled");

	dump_lock_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		tamper_reg |=> !dump_valid) else $error("dump after tamper");
endmodule : tss_supervisor

// file: verif/tss_panel.sv
// Front panel, speaker and relay observer counting status and alarm indications
`timescale 1ns/1ps
module tss_panel (
	input wire logic clk_sys,
	input wire logic speaker_on,
	input wire logic relay_pulse,
	input wire logic [3:0] led_on,
	output int beeps,
	output int pulses,
	output int flashes
);
	logic speaker_reg = 1'b0;
	logic relay_reg = 1'b0;
	logic all_reg = 1'b0;
	int beep_cnt = 0;
	int pulse_cnt = 0;
	int flash_cnt = 0;
	assign beeps = beep_cnt;
	assign pulses = pulse_cnt;
	assign flashes = flash_cnt;
	always @(posedge clk_sys) begin
		speaker_reg <= speaker_on;
		relay_reg <= relay_pulse;
		all_reg <= &led_on;
		if (speaker_on === 1'b1 && speaker_reg !== 1'b1) beep_cnt <= beep_cnt + 1;
		if (relay_pulse === 1'b1 && relay_reg !== 1'b1) pulse_cnt <= pulse_cnt + 1;
		if (&led_on === 1'b1 && all_reg !== 1'b1) flash_cnt <= flash_cnt + 1;
	end
endmodule : tss_panel

// file: verif/testbench.sv
// Self-checking bench for the tamper self-test supervisor
`timescale 1ns/1ps
module testbench;
	import tss_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic enclosure_open = 1'b0;
	logic bat_b = 1'b0;
	logic bat_a = 1'b0;
	logic encl_b = 1'b0;
	logic clk_en = 1'b1;
	localparam int BEEP = 4;
	localparam int TOUT = 50;
	logic factory_restore = 1'b0;
	tss_test_res_t test_res = 8'h00;
	tss_test_res_t res_f = 8'h00;
	logic [3:0] chan_sel_req = 4'h0;
	tss_log_req_t log_req = '0;
	logic admin_auth = 1'b0;
	logic dump_start = 1'b0;
	logic dump_next = 1'b0;
	logic prog_req = 1'b0;
	logic test_run, relays_closed, speaker_on, relay_pulse, erase_all, tamper_flag;
	logic prog_enable, dump_valid, tamper_f, tamper_b;
	logic [3:0] chan_sel, led_on, led_f, chan_f;
	tss_log_entry_t dump_entry;
	tss_log_entry_t sent[$];
	logic [1:0] modes[3] = '{TSS_MODE_FULL, TSS_MODE_KM, TSS_MODE_CUSTOM};
	int beeps, pulses, flashes, b0, p0, f0, i, k;
	int fails = 0;
	int samples_checked = 0;
	int seed = 98;

	always #25 clk_sys = ~clk_sys;

	tss_supervisor #(.BEEP_CYC(BEEP), .TEST_TIMEOUT_CYC(TOUT)) dut (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .clk_en(clk_en), .enclosure_open(enclosure_open), .battery_low(bat_a),
		.factory_restore(factory_restore), .test_res(test_res), .chan_sel_req(chan_sel_req),
		.log_req(log_req), .admin_auth(admin_auth), .dump_start(dump_start),
		.dump_next(dump_next), .prog_req(prog_req), .test_run(test_run), .chan_sel(chan_sel),
		.relays_closed(relays_closed), .led_on(led_on), .speaker_on(speaker_on),
		.relay_pulse(relay_pulse), .erase_all(erase_all), .tamper_flag(tamper_flag),
		.prog_enable(prog_enable), .dump_entry(dump_entry), .dump_valid(dump_valid));
	// Second unit fails its self-test, third loses its backup battery
	tss_supervisor #(.BEEP_CYC(BEEP), .TEST_TIMEOUT_CYC(TOUT)) dut_f (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .clk_en(clk_en), .enclosure_open(enclosure_open), .battery_low(bat_b),
		.factory_restore(factory_restore), .test_res(res_f), .chan_sel_req(chan_sel_req),
		.log_req(log_req), .admin_auth(admin_auth), .dump_start(dump_start),
		.dump_next(dump_next), .prog_req(prog_req), .test_run(), .chan_sel(chan_f),
		.relays_closed(), .led_on(led_f), .speaker_on(), .relay_pulse(), .erase_all(),
		.tamper_flag(tamper_f), .prog_enable(), .dump_entry(), .dump_valid());
	tss_supervisor #(.BEEP_CYC(BEEP), .TEST_TIMEOUT_CYC(TOUT)) dut_b (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .clk_en(clk_en), .enclosure_open(encl_b), .battery_low(bat_b),
		.factory_restore(factory_restore), .test_res(test_res), .chan_sel_req(chan_sel_req),
		.log_req(log_req), .admin_auth(admin_auth), .dump_start(dump_start),
		.dump_next(dump_next), .prog_req(prog_req), .test_run(), .chan_sel(), .relays_closed(),
		.led_on(), .speaker_on(), .relay_pulse(), .erase_all(), .tamper_flag(tamper_b),
		.prog_enable(), .dump_entry(), .dump_valid());
	tss_panel panel (.clk_sys(clk_sys), .speaker_on(speaker_on), .relay_pulse(relay_pulse),
		.led_on(led_on), .beeps(beeps), .pulses(pulses), .flashes(flashes));

	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string msg);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : tick

	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : close_out

	task automatic wait_run();
		for (int t = 0; t < 60 && relays_closed !== 1'b1; t++) tick(1);
	endtask : wait_run

	task automatic rewind();
		tick(1);
		dump_start <= 1'b1;
		tick(1);
		dump_start <= 1'b0;
	endtask : rewind

	task automatic dump_one(output tss_log_entry_t e, output logic got);
		tick(1);
		dump_next <= 1'b1;
		got = 1'b0;
		for (int t = 0; t < 4; t++) begin
			tick(1);
			dump_next <= 1'b0;
			if (dump_valid === 1'b1 && !got) begin
				got = 1'b1;
				e = dump_entry;
			end
		end
	endtask : dump_one

	function automatic tss_log_entry_t mk_ev(input int n);
		tss_log_entry_t e;
		e.kind = tss_event_t'(4'(n % 15 + 1));
		e.arg = (e.kind == ev_mode_upload) ? modes[n % 3] : 2'($random(seed));
		e.pass = 1'($random(seed));
		e.stamp = 32'(n * 64) + 32'($random(seed) & 63);
		return e;
	endfunction : mk_ev

	initial begin
		tss_log_entry_t e;
		logic got;
		tick(8);
		sys_rst <= 1'b0;
		chan_sel_req <= 4'h2;
		res_f <= 8'hf4;
		tick(2);
		// Failed unit shows solid LEDs for the cycle before its tamper alarm starts
		check(led_f, 4'hf, "fail LEDs"); // all LEDs on
		tick(2);
		check(test_run, 1'b1, "test not running"); // runs at power-up
		check(chan_sel, TSS_CH_ISOLATE, "channel during test"); // deselected
		test_res <= 8'hf0;
		wait_run();
		check(beeps, 1, "beep count"); // one beep
		check(pulses, 1, "relay pulse count"); // one pulse
		tick(2);
		check(chan_sel, 4'h2, "channel in run"); // normal operation
		check({tamper_f, chan_f}, 5'h10, "failed unit active"); // stays disabled
		$display("test power-up done");
		for (i = 0; i < 20; i++) begin
			chan_sel_req <= 4'h1 << ($random(seed) & 3);
			prog_req <= 1'($random(seed));
			tick(2);
			check(chan_sel, chan_sel_req, "channel follow"); // no user tamper
			check({prog_enable, tamper_flag}, 2'h0, "programming open"); // locked
		end
		chan_sel_req <= 4'h4;
		tick(2);
		// Clock enable low freezes every register but the log read-valid flag and the power-on marker
		clk_en <= 1'b0;
		chan_sel_req <= 4'h8;
		tick(3);
		check(chan_sel, 4'h4, "frozen channel"); // held while frozen
		clk_en <= 1'b1;
		tick(2);
		check(chan_sel, 4'h8, "thawed channel"); // normal operation
		$display("test channels done");
		for (i = 0; i < 110; i++) begin
			e = mk_ev(i);
			sent.push_back(e);
			tick(1);
			log_req <= {1'b1, e};
			tick(1);
			log_req <= '0;
		end
		rewind();
		dump_one(e, got);
		check(got, 1'b0, "dump without admin"); // refused
		admin_auth <= 1'b1;
		rewind();
		for (i = 10; i < 110; i++) begin
			dump_one(e, got);
			check(got, 1'b1, "dump missing"); // entry read
			check(e, sent[i], "log entry"); // oldest first
		end
		$display("test log done");
		for (k = 0; k < 2; k++) begin
			test_res <= 8'h00;
			if (k == 0) factory_restore <= 1'b1;
			else sys_rst <= 1'b1;
			tick(2);
			factory_restore <= 1'b0;
			sys_rst <= 1'b0;
			tick(2);
			check({test_run, relays_closed}, 2'h2, "rerun"); // restore and reset
			check(chan_sel, TSS_CH_ISOLATE, "channel in rerun"); // deselected
			test_res <= 8'hf0;
			wait_run();
			check(beeps, k + 2, "rerun beep"); // one beep
			check({tamper_flag, tamper_b}, 2'h0, "spurious tamper"); // no user tamper
		end
		$display("test rerun done");
		bat_b <= 1'b1;
		tick(6);
		check(tamper_b, 1'b1, "battery tamper"); // low battery
		enclosure_open <= 1'b1;
		tick(6);
		check(tamper_flag, 1'b1, "enclosure tamper"); // opened enclosure
		enclosure_open <= 1'b0;
		b0 = beeps;
		p0 = pulses;
		f0 = flashes;
		tick(40);
		check({beeps > b0 + 2, pulses > p0 + 2, flashes > f0 + 2}, 3'h7, "alarm");
		check({chan_sel, relays_closed}, 5'h00, "not isolated"); // isolation
		check(erase_all, 1'b1, "no erase"); // erase
		sys_rst <= 1'b1;
		factory_restore <= 1'b1;
		tick(2);
		sys_rst <= 1'b0;
		factory_restore <= 1'b0;
		tick(20);
		check(tamper_flag, 1'b1, "tamper cleared"); // sticky
		check({chan_sel, relays_closed}, 5'h00, "revived"); // stays disabled
		rewind();
		dump_one(e, got);
		check(got, 1'b0, "dump after tamper"); // no access
		$display("test tamper done");
		close_out();
	end

	initial begin
		repeat (6000) @(posedge clk_sys);
		fails++;
		close_out();
	end
endmodule : testbench
